// ==== rtl/hsb_hub_status_sideband.sv ====
// hub sideband status pins: reset filter, detects, straps, indicators
//
// Notes on behaviour
// (RL1) board holds reset low at least 5us
// (RL2) suspend role: high only configured and active
// (RL3) indicator role: suspend default, or remote wakeup
// (RL4) self power detect: low bus, high local
// (RL5) strap 1 sets high speed indicator polarity
// (RL6) indicator asserted high speed, negated full speed
// (RL7) watch upstream power; toggle forces reconnect
// (RL8) led dark until enabled; blink or breathe
// (RL9) both straps choose configuration method
// (RL10) straps sampled at reset release, then held
`timescale 1ns/10ps
module hsb_hub_status_sideband
    import hsb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    // board pins
    input  wire logic        systemResetN,
    input  wire logic        selfPowerDetect,
    input  wire logic        upstreamPowerDetect,
    input  wire logic        configMethodSelect0,
    input  wire logic        configMethodSelect1,
    input  wire logic        suspendWakeIndicatorIn,
    output logic             suspendWakeIndicatorOut,
    output logic             suspendWakeIndicatorOeN,
    output logic             highSpeedIndicator,
    output logic             generalLedOutput,
    // hub core side
    input  wire logic        hubConfigured,
    input  wire logic        hubSuspended,
    input  wire logic        upstreamHighSpeed,
    input  wire logic        remoteWakeEvent,
    output logic             hubReset,
    output logic             selfPowered,
    output logic             upstreamPowerPresent,
    output logic             upstreamReconnect,
    output logic [1:0]       configMethod,
    output logic             strapsValid,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);

    logic [7:0]  lowCount;      // cycles the reset pin has been low
    logic        extReset;      // qualified external reset
    logic        strap0;        // latched strap 0
    logic        strap1;        // latched strap 1, also hs polarity
    logic [4:0]  control;       // software control bits
    logic        powerChange;   // sticky: upstream power was lost
    logic [5:0]  wakeCount;     // remaining released cycles
    logic        accessValid;   // address phase accepted
    logic        pendWrite;     // data phase is a write
    logic [7:0]  pendAddr;      // address of pending data phase
    logic        clearChange;   // software clears powerChange
    logic [31:0] next_hrdata;   // read data for the next data phase
    logic [31:0] statusWord;    // live status register view
    hsb_role_t   role;          // indicator role

    assign role = hsb_role_t'(control[CTRL_ROLE_BIT]);

    // (RL1) reset pulse width counter
    // short glitches on the pin are filtered out instead of resetting
    always_ff @(posedge clock)
    begin
        if (rst || systemResetN)
            lowCount <= 8'h00;
        else if (lowCount != 8'(RESET_MIN_CYCLES))
            lowCount <= lowCount + 8'h01;
    end

    // (RL1) full reset once pulse is long enough
    always_ff @(posedge clock)
    begin
        if (rst)
            extReset <= 1'b0;
        else
            extReset <= !systemResetN &&
                        (lowCount >= 8'(RESET_MIN_CYCLES - 1));
    end

    // everything below restarts on either reset
    assign hubReset = rst || extReset;

    // (RL10) straps caught once after reset release
    always_ff @(posedge clock)
    begin
        if (hubReset)
        begin
            strap0      <= 1'b0;
            strap1      <= 1'b0;
            strapsValid <= 1'b0;
        end
        else if (!strapsValid)
        begin
            strap0      <= configMethodSelect0;
            strap1      <= configMethodSelect1;
            strapsValid <= 1'b1;
        end
    end

    // (RL9) method from both straps
    always_ff @(posedge clock)
    begin
        if (hubReset)
            configMethod <= 2'h0;
        else if (!strapsValid)
            configMethod <= {configMethodSelect1, configMethodSelect0};
    end

    // (RL4) low means bus powered only
    always_ff @(posedge clock)
    begin
        if (hubReset)
            selfPowered <= 1'b0;
        else
            selfPowered <= selfPowerDetect;
    end

    // (RL7) upstream power level for the hub core
    always_ff @(posedge clock)
    begin
        if (hubReset)
            upstreamPowerPresent <= 1'b0;
        else
            upstreamPowerPresent <= upstreamPowerDetect;
    end

    // (RL7) power return asks core to reconnect
    // the core renegotiates without a full reset of the hub
    always_ff @(posedge clock)
    begin
        if (hubReset)
            upstreamReconnect <= 1'b0;
        else
            upstreamReconnect <= upstreamPowerDetect &&
                                 !upstreamPowerPresent;
    end

    // (RL7) sticky loss flag, set wins over clear
    always_ff @(posedge clock)
    begin
        if (hubReset)
            powerChange <= 1'b0;
        else if (upstreamPowerPresent && !upstreamPowerDetect)
            powerChange <= 1'b1;
        else if (clearChange)
            powerChange <= 1'b0;
    end

    // (RL5) (RL6) polarity from strap 1
    // reset loads 0 directly, so the pin idles low during reset whatever the strap
    always_ff @(posedge clock)
    begin
        if (hubReset)
            highSpeedIndicator <= 1'b0;
        else
            highSpeedIndicator <= upstreamHighSpeed ^ strap1;
    end

    // (RL3) wakeup role release timer
    always_ff @(posedge clock)
    begin
        if (hubReset || role != ROLE_WAKE)
            wakeCount <= 6'h00;
        else if (remoteWakeEvent)
            wakeCount <= 6'(WAKE_PULSE_CYCLES);
        else if (wakeCount != 6'h00)
            wakeCount <= wakeCount - 6'h01;
    end

    // (RL2) (RL3) open-drain indicator drive
    // pin only ever pulls low; released means high through the pull-up
    assign suspendWakeIndicatorOut = 1'b0;
    always_ff @(posedge clock)
    begin
        if (hubReset)
            suspendWakeIndicatorOeN <= 1'b0;
        else if (role == ROLE_SUSPEND)
            suspendWakeIndicatorOeN <= hubConfigured && !hubSuspended;
        else
            suspendWakeIndicatorOeN <= remoteWakeEvent ||
                                       (wakeCount > 6'h01);
    end

    // (RL8) led pattern engine
    hsb_led_pattern ledEngine (
        .clock   (clock),
        .rst     (hubReset),
        .enable  (control[CTRL_LED_EN_BIT]),
        .breathe (control[CTRL_BREATHE_BIT]),
        .rate    (control[CTRL_RATE_LSB +: 2]),
        .ledOut  (generalLedOutput)
    );

    // bus slave never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase capture
    always_ff @(posedge clock)
    begin
        if (hubReset)
        begin
            accessValid <= 1'b0;
            pendWrite   <= 1'b0;
            pendAddr    <= 8'h00;
        end
        else if (hready)
        begin
            accessValid <= hsel && htrans[1];
            pendWrite   <= hwrite;
            pendAddr    <= haddr;
        end
    end

    // control register written in the data phase
    always_ff @(posedge clock)
    begin
        if (hubReset)
            control <= CTRL_RESET;
        else if (accessValid && pendWrite && pendAddr == ADDR_CONTROL)
            control <= hwdata[4:0];
    end

    // write one to the change bit clears it
    assign clearChange = accessValid && pendWrite &&
                         pendAddr == ADDR_STATUS &&
                         hwdata[STAT_PWR_CHG_BIT];

    // live status view
    always_comb
    begin
        statusWord = 32'h00000000;
        statusWord[STAT_SELF_PWR_BIT] = selfPowered;
        statusWord[STAT_UP_PWR_BIT]   = upstreamPowerPresent;
        statusWord[STAT_STRAP0_BIT]   = strap0;
        statusWord[STAT_STRAP1_BIT]   = strap1;
        statusWord[STAT_PWR_CHG_BIT]  = powerChange;
        statusWord[STAT_PIN_BIT]      = suspendWakeIndicatorIn;
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        next_hrdata = 32'h00000000;
        if (haddr == ADDR_CONTROL)
            next_hrdata = {27'h0000000, control};
        else if (haddr == ADDR_STATUS)
            next_hrdata = statusWord;
    end

    // read data registered at the address phase edge
    always_ff @(posedge clock)
    begin
        if (hubReset)
            hrdata <= 32'h00000000;
        else if (hready && hsel && htrans[1] && !hwrite)
            hrdata <= next_hrdata;
    end

    // (RL1) long pulse gives internal reset
    a_ext_reset_take: assert property (@(posedge clock) disable iff (rst)
        (!systemResetN && lowCount == 8'(RESET_MIN_CYCLES - 1))
        |=> extReset) // RL1
        else $error("long reset pulse not taken");

    // (RL2) suspend role level
    a_suspend_level: assert property (@(posedge clock)
        disable iff (hubReset)
        $past(role == ROLE_SUSPEND && !hubReset) |->
        suspendWakeIndicatorOeN == $past(hubConfigured && !hubSuspended))
        // RL2
        else $error("suspend indicator level wrong");

    // (RL3) wakeup role releases the pin
    a_wake_release: assert property (@(posedge clock)
        disable iff (hubReset)
        (role == ROLE_WAKE && remoteWakeEvent) ##1 (role == ROLE_WAKE)
        |-> suspendWakeIndicatorOeN) // RL3
        else $error("wakeup event not signalled");

    // (RL4) self power follows its pin
    a_self_power: assert property (@(posedge clock) disable iff (hubReset)
        $past(!hubReset) |-> selfPowered == $past(selfPowerDetect)) // RL4
        else $error("self power level wrong");

    // (RL5) (RL6) polarity and speed
    a_hs_polarity: assert property (@(posedge clock)
        disable iff (hubReset)
        $past(strapsValid) |->
        highSpeedIndicator == ($past(upstreamHighSpeed) ^ strap1)) // RL5
        else $error("high speed indicator wrong");

    // (RL7) loss sets the sticky flag
    a_power_loss: assert property (@(posedge clock) disable iff (hubReset)
        (upstreamPowerPresent && !upstreamPowerDetect) |=> powerChange)
        // RL7
        else $error("power loss not flagged");

    // (RL7) return gives one reconnect pulse
    a_reconnect_pulse: assert property (@(posedge clock)
        disable iff (hubReset)
        (upstreamPowerDetect && !upstreamPowerPresent) |=>
        upstreamReconnect ##1 !upstreamReconnect) // RL7
        else $error("reconnect pulse wrong");

    // (RL9) method matches both straps
    a_config_method: assert property (@(posedge clock)
        disable iff (hubReset)
        strapsValid |-> configMethod == {strap1, strap0}) // RL9
        else $error("configuration method wrong");

    // (RL10) straps held after capture
    a_straps_held: assert property (@(posedge clock) disable iff (hubReset)
        $past(strapsValid) |-> $stable(strap0) && $stable(strap1)) // RL10
        else $error("straps changed during operation");

endmodule

// ==== rtl/hsb_pkg.sv ====
// constants shared by the hub status sideband logic
package hsb_pkg;

    // clock rate and derived timing
    localparam int CLOCK_MHZ          = 40;
    // shortest external reset pulse, in ns
    localparam int RESET_MIN_NS       = 5000;
    // least time rounds up to whole cycles
    localparam int RESET_MIN_CYCLES   = (RESET_MIN_NS * CLOCK_MHZ + 999) / 1000;
    // width of the released pulse in wakeup role, in ns
    localparam int WAKE_PULSE_NS      = 1000;
    localparam int WAKE_PULSE_CYCLES  = (WAKE_PULSE_NS * CLOCK_MHZ + 999) / 1000;
    // led time base, in ns
    localparam int LED_TICK_NS        = 100000;
    localparam int LED_TICK_CYCLES    = (LED_TICK_NS * CLOCK_MHZ) / 1000;
    // blink half period at the fastest rate, in led ticks
    localparam logic [15:0] LED_BLINK_TICKS = 16'h07d0;
    // breathe steps are this shift shorter than a blink half period
    localparam int LED_BREATHE_SHIFT  = 9;

    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;

    // control register fields
    localparam int CTRL_ROLE_BIT      = 0;
    localparam int CTRL_LED_EN_BIT    = 1;
    localparam int CTRL_BREATHE_BIT   = 2;
    localparam int CTRL_RATE_LSB      = 3;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // status register fields
    localparam int STAT_SELF_PWR_BIT  = 0;
    localparam int STAT_UP_PWR_BIT    = 1;
    localparam int STAT_STRAP0_BIT    = 2;
    localparam int STAT_STRAP1_BIT    = 3;
    localparam int STAT_PWR_CHG_BIT   = 4;
    localparam int STAT_PIN_BIT       = 5;

    // role of the suspend / wakeup indicator
    typedef enum logic {
        ROLE_SUSPEND = 1'b0,
        ROLE_WAKE    = 1'b1
    } hsb_role_t;

endpackage

// ==== rtl/hsb_led_pattern.sv ====
// blink and breathe pattern generator for the general led
`timescale 1ns/10ps
module hsb_led_pattern
    import hsb_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       enable,   // led allowed to light
    input  wire logic       breathe,  // 1 breathe, 0 blink
    input  wire logic [1:0] rate,     // 0 fastest, 3 slowest
    output logic            ledOut    // active high led drive
);

    logic [11:0] tickCount;   // divides clock to led tick
    logic [15:0] stepCount;   // ticks since last pattern step
    logic [15:0] blinkLimit;  // ticks per blink half period
    logic [15:0] stepLimit;   // ticks per step of current pattern
    logic        tick;        // one led tick
    logic        step;        // one pattern step
    logic        blinkLevel;  // square wave for blinking
    logic [7:0]  duty;        // breathe brightness
    logic        rampDown;    // breathe direction
    logic [7:0]  pwmCount;    // free pwm ramp

    // slower rates double the period per step of rate
    assign blinkLimit = LED_BLINK_TICKS << rate;
    assign stepLimit  = breathe ? (blinkLimit >> LED_BREATHE_SHIFT)
                                : blinkLimit;
    assign tick = (tickCount == 12'(LED_TICK_CYCLES - 1));
    assign step = tick && (stepCount >= stepLimit - 16'h0001);

    // time base; held at zero while disabled so patterns start clean
    always_ff @(posedge clock)
    begin
        if (rst || !enable || tick)
            tickCount <= 12'h000;
        else
            tickCount <= tickCount + 12'h001;
    end

    // step counter
    always_ff @(posedge clock)
    begin
        if (rst || !enable || step)
            stepCount <= 16'h0000;
        else if (tick)
            stepCount <= stepCount + 16'h0001;
    end

    // blink square wave
    always_ff @(posedge clock)
    begin
        if (rst || !enable)
            blinkLevel <= 1'b0;
        else if (step && !breathe)
            blinkLevel <= !blinkLevel;
    end

    // breathe ramp, up to full then back to dark
    always_ff @(posedge clock)
    begin
        if (rst || !enable)
        begin
            duty     <= 8'h00;
            rampDown <= 1'b0;
        end
        else if (step && breathe)
        begin
            if (!rampDown)
            begin
                if (duty == 8'hff)
                    rampDown <= 1'b1;
                else
                    duty <= duty + 8'h01;
            end
            else if (duty == 8'h00)
                rampDown <= 1'b0;
            else
                duty <= duty - 8'h01;
        end
    end

    // pwm ramp runs freely; its phase does not matter to the eye
    always_ff @(posedge clock)
    begin
        if (rst)
            pwmCount <= 8'h00;
        else
            pwmCount <= pwmCount + 8'h01;
    end

    // (RL8) dark until enabled, else pattern
    always_ff @(posedge clock)
    begin
        if (rst || !enable)
            ledOut <= 1'b0;
        else if (breathe)
            ledOut <= (pwmCount < duty);
        else
            ledOut <= blinkLevel;
    end

    // (RL8) disabled led stays dark
    a_led_dark_off: assert property (@(posedge clock) disable iff (rst)
        !enable |=> !ledOut) // RL8
        else $error("led lit while disabled");

endmodule

// ==== tb/hsb_board_model.sv ====
// board side model: reset pulser and pulled-up indicator wire
`timescale 1ns/10ps
module hsb_board_model
(
    input  wire logic        clock,
    input  wire logic        pulseReq,     // start a reset pulse
    input  wire logic [15:0] pulseLen,     // pulse width in cycles
    input  wire logic        indOut,       // device pin drive value
    input  wire logic        indOeN,       // device enable, low drives
    output logic             systemResetN, // board reset, active low
    output logic             indWire       // level seen on the wire
);
    logic [15:0] lowLeft = 16'h0000; // cycles of reset still held

    always @(posedge clock)
    begin
        if (pulseReq)
            lowLeft <= pulseLen;
        else if (lowLeft != 16'h0000)
            lowLeft <= lowLeft - 16'h0001;
    end

    assign systemResetN = (lowLeft == 16'h0000);
    // the pull-up wins whenever the device lets go of the pin
    assign indWire = indOeN ? 1'b1 : indOut;
endmodule

// ==== tb/hsb_hub_status_sideband_tb.sv ====
// self-checking bench for the hub sideband status block
`timescale 1ns/10ps
module hsb_hub_status_sideband_tb;
    import hsb_pkg::*;
    logic clock = 1'b0, rst = 1'b1, sp = 1'b0, upd = 1'b1;
    logic s0 = 1'b1, s1 = 1'b0, cfg = 1'b0, susp = 1'b0, hs = 1'b0;
    logic wake = 1'b0, hsel = 1'b0, hwrite = 1'b0, pReq = 1'b0;
    logic [7:0]  haddr = 8'h00;     // bus address
    logic [1:0]  htrans = 2'b00;    // bus transfer kind
    logic [2:0]  hsize = 3'b010;    // always a word
    logic [31:0] hwdata = 32'h0, rd; // write data, last read
    logic [15:0] pLen = 16'h0000;   // reset pulse width
    wire ready, resp, oeN, pinOut, wire1, resetN, led, hsInd, hubRst;
    wire selfP, upP, recon, strapsOk;
    wire [1:0]  method;
    wire [31:0] hrdata;
    int errTotal = 0, nCompared = 0, t, n;
    // rows: cfg susp hs sp, then wire, hs indicator, self powered
    logic [6:0] rows [8] = '{7'b1000_100, 7'b1100_000, 7'b0010_010,
        7'b1011_111, 7'b0101_001, 7'b1110_010, 7'b0000_000, 7'b1001_101};

    initial forever #12.5 clock = ~clock;

    hsb_board_model i_board (.clock(clock), .pulseReq(pReq),
        .pulseLen(pLen), .indOut(pinOut), .indOeN(oeN),
        .systemResetN(resetN), .indWire(wire1));
    hsb_hub_status_sideband i_dut (.clock(clock), .rst(rst),
        .systemResetN(resetN), .selfPowerDetect(sp),
        .upstreamPowerDetect(upd), .configMethodSelect0(s0),
        .configMethodSelect1(s1), .suspendWakeIndicatorIn(wire1),
        .suspendWakeIndicatorOut(pinOut), .suspendWakeIndicatorOeN(oeN),
        .highSpeedIndicator(hsInd), .generalLedOutput(led),
        .hubConfigured(cfg), .hubSuspended(susp), .upstreamHighSpeed(hs),
        .remoteWakeEvent(wake), .hubReset(hubRst), .selfPowered(selfP),
        .upstreamPowerPresent(upP), .upstreamReconnect(recon),
        .configMethod(method), .strapsValid(strapsOk), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(ready), .hreadyout(ready), .hresp(resp),
        .hrdata(hrdata));

    // verdict and end of run
    task automatic summarize();
        $display("compared %0d, mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one comparison, counted
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    // a used-up wait is a mismatch and ends the run
    task automatic gone(input int used, input int limit);
        if (used >= limit)
        begin
            errTotal++;
            summarize();
        end
    endtask

    // waits a count of edges, then settles at the falling edge
    task automatic pass(input int k);
        repeat (k) @(posedge clock);
        @(negedge clock);
    endtask

    // one single word transfer; holds each phase until hready is high
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int c;
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        c = 0;
        do begin @(posedge clock); c++; end while (ready !== 1'b1 && c < 50);
        gone(c, 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        c = 0;
        do begin @(posedge clock); c++; end while (ready !== 1'b1 && c < 50);
        gone(c, 50);
        rd = hrdata;
    endtask

    initial
    begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        pass(3);
        chk(method, 2'b01);
        chk(strapsOk, 1'b1);
        chk(pinOut, 1'b0);
        chk(led, 1'b0);
        s1 <= 1'b1;
        s0 <= 1'b0;
        pass(3);
        chk(method, 2'b01);
        chk(hsInd, 1'b0);
        // ordinary cases from the table, strap 1 latched at 0
        foreach (rows[i])
        begin
            @(posedge clock);
            {cfg, susp, hs, sp} <= rows[i][6:3];
            pass(2);
            chk(wire1, rows[i][2]);
            chk(hsInd, rows[i][1]);
            chk(selfP, rows[i][0]);
        end
        // power loss is sticky until written off, return pulses once
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[4:0], 5'h07);
        upd <= 1'b0;
        pass(3);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[4:1], 4'ha);
        ahb(1'b1, ADDR_STATUS, 32'h10);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[4], 1'b0);
        upd <= 1'b1;
        t = 0;
        while (recon !== 1'b1 && t < 10) begin @(negedge clock); t++; end
        gone(t, 10);
        pass(0);
        chk(recon, 1'b0);
        chk(upP, 1'b1);
        // unmapped place: write lost, read zero
        ahb(1'b1, 8'h08, 32'h1f);
        ahb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b0, ADDR_CONTROL, 32'h0);
        chk(rd, 32'h0);
        // wakeup role: pin low, released once per event
        {cfg, susp} <= 2'b10;
        ahb(1'b1, ADDR_CONTROL, 32'h1);
        pass(2);
        chk(wire1, 1'b0);
        wake <= 1'b1;
        @(posedge clock);
        wake <= 1'b0;
        t = 0;
        while (wire1 !== 1'b1 && t < 10) begin @(negedge clock); t++; end
        gone(t, 10);
        n = 0;
        while (wire1 === 1'b1 && n < 100) begin @(negedge clock); n++; end
        chk(n, WAKE_PULSE_CYCLES);
        // breathing led lights up once enabled, dark again when not
        ahb(1'b1, ADDR_CONTROL, 32'h6);
        t = 0;
        while (led !== 1'b1 && t < 80000) begin @(negedge clock); t++; end
        gone(t, 80000);
        ahb(1'b1, ADDR_CONTROL, 32'h4);
        pass(2);
        chk(led, 1'b0);
        // a short board pulse is ignored
        s0 <= 1'b1;
        pLen <= 16'd150;
        pReq <= 1'b1;
        @(posedge clock);
        pReq <= 1'b0;
        n = 0;
        repeat (200) begin @(negedge clock); n += int'(hubRst === 1'b1); end
        chk(n, 0);
        // a full pulse resets and takes the new straps
        pLen <= 16'd210;
        pReq <= 1'b1;
        @(posedge clock);
        pReq <= 1'b0;
        t = 0;
        while (hubRst !== 1'b1 && t < 260) begin @(negedge clock); t++; end
        gone(t, 260);
        t = 0;
        while (hubRst !== 1'b0 && t < 100) begin @(negedge clock); t++; end
        gone(t, 100);
        pass(3);
        chk(method, 2'b11);
        chk(hsInd, 1'b1);
        hs <= 1'b1;
        pass(2);
        chk(hsInd, 1'b0);
        ahb(1'b0, ADDR_CONTROL, 32'h0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule
